// File: pkg/blp_pkg.sv
// Package for the backlight PWM output block: register map, fields, resets.
// Assumes a single 10 MHz system clock and a plain register port.
package blp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BLP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] BLP_ADDR_MODE = 8'h01;
  localparam logic [7:0] BLP_ADDR_MIN_DUTY = 8'h02;
  localparam logic [7:0] BLP_ADDR_DIVIDER = 8'h03;
  localparam logic [7:0] BLP_ADDR_OFFSET = 8'h04;
  localparam logic [7:0] BLP_ADDR_FORCE = 8'h05;
  localparam logic [7:0] BLP_ADDR_DUTY_IN = 8'h06;
  localparam logic [7:0] BLP_ADDR_CLK_SEL = 8'h09;
  localparam logic [7:0] BLP_ADDR_STATUS = 8'h0A;

  // ----------------------------------------------------------------
  // Control and force register fields
  // ----------------------------------------------------------------
  localparam int BLP_CTRL_ON_BIT = 0;
  localparam int BLP_CTRL_BLOCK_BIT = 1;
  localparam int BLP_CTRL_POL_BIT = 2;
  localparam int BLP_CTRL_BOOST_BIT = 3;
  localparam int BLP_CTRL_FLOAT_BIT = 4;
  localparam int BLP_FORCE_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BLP_CTRL_RESET = 8'h00;
  localparam logic [1:0] BLP_MODE_RESET = 2'h0;
  localparam logic [7:0] BLP_MIN_RESET = 8'h00;
  localparam logic [7:0] BLP_DIV_RESET = 8'h01;
  localparam logic [4:0] BLP_OFFSET_RESET = 5'h00;
  localparam logic [7:0] BLP_FORCE_DUTY_RESET = 8'hFF;
  localparam logic [7:0] BLP_DUTY_IN_RESET = 8'hFF;
  localparam logic [1:0] BLP_CLK_SEL_RESET = 2'h1;
  localparam logic [7:0] BLP_RDATA_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  localparam logic [1:0] BLP_CLK_HALF = 2'h0;
  localparam logic [1:0] BLP_CLK_FULL = 2'h1;

  typedef enum logic [1:0] {
    BLP_MODE_OFF = 2'b00,
    BLP_MODE_UI = 2'b01,
    BLP_MODE_STILL = 2'b10,
    BLP_MODE_MOVING = 2'b11
  } blp_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } blp_bus_t;

  // Values latched at each period boundary
  typedef struct packed {
    logic [8:0] duty;
    logic [7:0] divider;
    logic pol;
  } blp_period_t;

endpackage

// File: verilog/blp_top.sv
// Backlight PWM generator with a plain register port and a tri-state pin.
// Assumes synchronous inputs; the pin wire is resolved from the enable.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module blp_top
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] computed_duty_in,
  output logic [7:0] rdata_out,
  output logic backlight_pwm_pin_out,
  output logic backlight_pwm_pin_oe_out,
  output logic drive_strength_boost_out,
  output logic period_start_out
);
  import blp_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  blp_bus_t bus;
  logic [7:0] ctrl_q;
  logic [1:0] mode_q;
  logic [7:0] min_duty_limit_q;
  logic [7:0] period_divider_q;
  logic [4:0] duty_offset_q;
  logic forced_duty_enable_q;
  logic [7:0] forced_duty_value_q;
  logic [7:0] duty_in_q;
  logic [1:0] pwm_clock_select_q;
  logic [7:0] rdata_q;
  logic half_q;
  logic [7:0] presc_q;
  logic [7:0] step_q;
  blp_period_t cur_q;
  logic pin_q;
  logic oe_q;
  logic boost_q;
  logic start_q;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BLP_SEL_NONE = 4'b0000,
    BLP_SEL_CTRL = 4'b0001,
    BLP_SEL_MODE = 4'b0010,
    BLP_SEL_MIN = 4'b0011,
    BLP_SEL_DIV = 4'b0100,
    BLP_SEL_OFF = 4'b0101,
    BLP_SEL_FORCE = 4'b0110,
    BLP_SEL_DUTY = 4'b0111,
    BLP_SEL_CLK = 4'b1000,
    BLP_SEL_STATUS = 4'b1001
  } blp_reg_sel_t;

  // Maps a bus address onto the register that it selects
  function automatic blp_reg_sel_t reg_select(input logic [7:0] a);
  begin
    if (a == BLP_ADDR_CTRL)
      reg_select = BLP_SEL_CTRL;
    else if (a == BLP_ADDR_MODE)
      reg_select = BLP_SEL_MODE;
    else if (a == BLP_ADDR_MIN_DUTY)
      reg_select = BLP_SEL_MIN;
    else if (a == BLP_ADDR_DIVIDER)
      reg_select = BLP_SEL_DIV;
    else if (a == BLP_ADDR_OFFSET)
      reg_select = BLP_SEL_OFF;
    else if (a == BLP_ADDR_FORCE)
      reg_select = BLP_SEL_FORCE;
    else if (a == BLP_ADDR_DUTY_IN)
      reg_select = BLP_SEL_DUTY;
    else if (a == BLP_ADDR_CLK_SEL)
      reg_select = BLP_SEL_CLK;
    else if (a == BLP_ADDR_STATUS)
      reg_select = BLP_SEL_STATUS;
    else
      reg_select = BLP_SEL_NONE;
  end
  endfunction

  blp_reg_sel_t bus_sel;

  assign bus_sel = reg_select(bus.addr);

  wire wr_ctrl = bus.wr && (bus_sel == BLP_SEL_CTRL);
  wire wr_mode = bus.wr && (bus_sel == BLP_SEL_MODE);
  wire wr_min = bus.wr && (bus_sel == BLP_SEL_MIN);
  wire wr_div = bus.wr && (bus_sel == BLP_SEL_DIV);
  wire wr_off = bus.wr && (bus_sel == BLP_SEL_OFF);
  wire wr_force = bus.wr && (bus_sel == BLP_SEL_FORCE);
  wire wr_duty = bus.wr && (bus_sel == BLP_SEL_DUTY);
  wire wr_clk = bus.wr && (bus_sel == BLP_SEL_CLK);

  wire backlight_output_on = ctrl_q[BLP_CTRL_ON_BIT];
  wire brightness_block_enable = ctrl_q[BLP_CTRL_BLOCK_BIT];
  wire pwm_polarity_invert = ctrl_q[BLP_CTRL_POL_BIT];
  wire drive_strength_boost = ctrl_q[BLP_CTRL_BOOST_BIT];
  wire pwm_output_float = ctrl_q[BLP_CTRL_FLOAT_BIT];

  // ----------------------------------------------------------------
  // Duty computation
  // ----------------------------------------------------------------
  wire [7:0] raw_duty = forced_duty_enable_q ? forced_duty_value_q :
    duty_in_q;
  wire [7:0] clamped_duty = (raw_duty < min_duty_limit_q) ?
    min_duty_limit_q : raw_duty;
  wire [9:0] duty_sum = {2'h0, clamped_duty} + 10'h001 +
    {5'h00, duty_offset_q};
  wire [8:0] duty_count = (duty_sum > 10'h100) ? 9'h100 :
    duty_sum[8:0];

  // ----------------------------------------------------------------
  // Source clock and period timing
  // ----------------------------------------------------------------
  wire src_tick = (pwm_clock_select_q == BLP_CLK_HALF) ? half_q :
    1'b1;
  wire [7:0] div_eff = (cur_q.divider == 8'h00) ? 8'h01 : cur_q.divider;
  wire step_end = src_tick && (presc_q >= div_eff - 8'h01);
  wire period_end = step_end && (step_q == 8'hFF);
  wire [8:0] step_ext = {1'b0, step_q};
  wire pwm_active = step_ext < cur_q.duty;
  wire pwm_mode = (mode_q != BLP_MODE_OFF) || forced_duty_enable_q;
  wire level_active = pwm_mode ? pwm_active : 1'b1;
  wire enabled = backlight_output_on && brightness_block_enable;
  wire pin_d = enabled ? (level_active ^ cur_q.pol) :
    pwm_polarity_invert;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_mux = (bus_sel == BLP_SEL_CTRL) ? ctrl_q :
    (bus_sel == BLP_SEL_MODE) ? {6'h00, mode_q} :
    (bus_sel == BLP_SEL_MIN) ? min_duty_limit_q :
    (bus_sel == BLP_SEL_DIV) ? period_divider_q :
    (bus_sel == BLP_SEL_OFF) ? {3'h0, duty_offset_q} :
    (bus_sel == BLP_SEL_FORCE) ? forced_duty_value_q :
    (bus_sel == BLP_SEL_DUTY) ? duty_in_q :
    (bus_sel == BLP_SEL_CLK) ? {6'h00, pwm_clock_select_q} :
    (bus_sel == BLP_SEL_STATUS) ? step_q :
    BLP_RDATA_ZERO;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q <= BLP_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= {3'h0, bus.wdata[4:0]};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      mode_q <= BLP_MODE_RESET;
    end
    else if (wr_mode)
    begin
      mode_q <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      min_duty_limit_q <= BLP_MIN_RESET;
    end
    else if (wr_min)
    begin
      min_duty_limit_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      period_divider_q <= BLP_DIV_RESET;
    end
    else if (wr_div)
    begin
      period_divider_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      duty_offset_q <= BLP_OFFSET_RESET;
    end
    else if (wr_off)
    begin
      duty_offset_q <= bus.wdata[4:0];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      forced_duty_value_q <= BLP_FORCE_DUTY_RESET;
    end
    else if (wr_force)
    begin
      forced_duty_value_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      forced_duty_enable_q <= 1'b0;
    end
    else if (wr_force)
    begin
      forced_duty_enable_q <= 1'b1;
    end
    else if (wr_mode)
    begin
      forced_duty_enable_q <= bus.wdata[7];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      duty_in_q <= BLP_DUTY_IN_RESET;
    end
    else if (wr_duty)
    begin
      duty_in_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      pwm_clock_select_q <= BLP_CLK_SEL_RESET;
    end
    else if (wr_clk)
    begin
      pwm_clock_select_q <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      rdata_q <= BLP_RDATA_ZERO;
    end
    else
    begin
      rdata_q <= bus.rd ? rd_mux : BLP_RDATA_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // PWM engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      half_q <= 1'b0;
      presc_q <= 8'h00;
      step_q <= 8'h00;
      cur_q <= '{duty: 9'h100, divider: BLP_DIV_RESET, pol: 1'b0};
      start_q <= 1'b0;
    end
    else
    begin
      half_q <= ~half_q;
      start_q <= period_end;
      if (step_end)
      begin
        presc_q <= 8'h00;
        step_q <= step_q + 8'h01;
      end
      else if (src_tick)
        presc_q <= presc_q + 8'h01;
      if (period_end)
        cur_q <= '{duty: duty_count, divider: period_divider_q,
                   pol: pwm_polarity_invert};
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      pin_q <= 1'b0;
      oe_q <= 1'b1;
      boost_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_d;
      oe_q <= ~pwm_output_float;
      boost_q <= drive_strength_boost;
    end
  end

  assign rdata_out = rdata_q;
  assign backlight_pwm_pin_out = pin_q;
  assign backlight_pwm_pin_oe_out = oe_q;
  assign drive_strength_boost_out = boost_q;
  assign period_start_out = start_q;

endmodule

// File: verif/blp_assertions.sv
// Checker for the backlight PWM block, bound to blp_top.
// Sees only the top ports; one clock domain.
`timescale 1ns/1ps
module blp_assertions
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic backlight_pwm_pin_out,
  input wire logic backlight_pwm_pin_oe_out,
  input wire logic drive_strength_boost_out,
  input wire logic period_start_out
);
  import blp_pkg::*;
  logic [7:0] ctrl_q;
  logic [9:0] gap_q;
  logic seen_q;
  wire ctrl_wr = wr_in && addr_in == BLP_ADDR_CTRL;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q <= BLP_CTRL_RESET;
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_q <= wdata_in;
      if (period_start_out)
        seen_q <= 1'b1;
      gap_q <= period_start_out ? '0 : gap_q + (gap_q != 10'h3ff);
    end
  end
  property p_oe;
    ctrl_q == $past(ctrl_q) |-> backlight_pwm_pin_oe_out == !ctrl_q[4];
  endproperty
  a_oe: assert property (p_oe) else $error("enable differs from float");
  property p_oe_rst;
    $rose(resetn_in) |-> backlight_pwm_pin_oe_out;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin not driven");
  property p_float_wr;
    ctrl_wr && wdata_in[4] |=> ##1 !backlight_pwm_pin_oe_out;
  endproperty
  a_float_wr: assert property (p_float_wr) else $error("float late");
  property p_idle;
    !(ctrl_q[0] && ctrl_q[1]) && !ctrl_q[4] && ctrl_q == $past(ctrl_q)
      |-> backlight_pwm_pin_out == ctrl_q[2];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_boost;
    ctrl_q == $past(ctrl_q) |-> drive_strength_boost_out == ctrl_q[3];
  endproperty
  a_boost: assert property (p_boost) else $error("drive bit wrong");
  property p_rd;
    !rd_in || addr_in == 8'h07 |=> rdata_out == BLP_RDATA_ZERO;
  endproperty
  a_rd: assert property (p_rd) else $error("read data not zero");
  property p_pulse;
    period_start_out |=> !period_start_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long start pulse");
  property p_period;
    period_start_out && seen_q |-> gap_q >= 10'h0ff;
  endproperty
  a_period: assert property (p_period) else $error("short period");
endmodule

bind blp_top blp_assertions u_chk (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .backlight_pwm_pin_out(backlight_pwm_pin_out),
  .backlight_pwm_pin_oe_out(backlight_pwm_pin_oe_out),
  .drive_strength_boost_out(drive_strength_boost_out),
  .period_start_out(period_start_out));

// File: verif/blp_led_model.sv
// Partner model: input stage of the external LED driver.
// Resolves the pin wire and counts active cycles per PWM period.
`timescale 1ns/1ps
module blp_led_model
(
  input wire logic clk_sys_in,
  input wire logic pin_in,
  input wire logic oe_in,
  input wire logic period_start_in,
  output logic level_out,
  output logic done_out,
  output logic [10:0] highs_out
);
  logic last_q = 1'b0;
  logic [10:0] acc_q = '0;
  // A floating pin shows the inverse of its last level
  assign level_out = oe_in ? pin_in : ~last_q;
  always_ff @(posedge clk_sys_in)
  begin
    last_q <= level_out;
    done_out <= period_start_in;
    if (period_start_in)
    begin
      highs_out <= acc_q;
      acc_q <= {10'h000, level_out};
    end
    else
      acc_q <= acc_q + level_out;
  end
endmodule

// File: verif/blp_top_test.sv
// Testbench for blp_top with the LED driver model on the pin.
// Register port driven on the rising edge; read data and period counts checked from queues.
`timescale 1ns/1ps
module blp_top_test;
  import blp_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, rd_d = 0, pin, oe, bst, pst, lvl, done;
  logic [7:0] addr = 0, wd = 0, cd = 0, rdata, d;
  logic [10:0] highs;
  logic [7:0] rq[$];
  logic [10:0] pq[$];
  int n_fail = 0, checks = 0, cyc = 0, i;
  blp_top dut (.clk_sys_in(clk), .resetn_in(rstn), .addr_in(addr),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .computed_duty_in(cd),
    .rdata_out(rdata), .backlight_pwm_pin_out(pin),
    .backlight_pwm_pin_oe_out(oe), .drive_strength_boost_out(bst),
    .period_start_out(pst));
  blp_led_model u_led (.clk_sys_in(clk), .pin_in(pin), .oe_in(oe),
    .period_start_in(pst), .level_out(lvl), .done_out(done),
    .highs_out(highs));
  initial forever #50 clk = ~clk;
  task chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    cd <= $urandom;
    rd_d <= rd;
    if (rd_d) chk({3'h0, rdata}, {3'h0, rq.pop_front()});
    if (done && pq.size() > 0) chk(highs, pq.pop_front());
    if (cyc == 60000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  task w(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task r(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  // Program one setting and expect active clocks over a whole period
  task go(input logic [7:0] c, m, dv, mn, of, input logic fe, input logic cs);
    int k;
    w(BLP_ADDR_CTRL, c);
    w(BLP_ADDR_MODE, m);
    w(BLP_ADDR_MIN_DUTY, mn);
    w(BLP_ADDR_OFFSET, of);
    w(BLP_ADDR_DIVIDER, dv);
    w(BLP_ADDR_CLK_SEL, {7'h00, cs});
    w(BLP_ADDR_DUTY_IN, d);
    if (fe) w(BLP_ADDR_FORCE, d);
    k = (d > mn ? d : mn) + 1 + of;
    if (fe) k = d + 1;
    else if (m[1:0] == 0) k = 256;
    if (k > 256) k = 256;
    if (c[1:0] != 2'b11) k = 0;
    if (c[2]) k = 256 - k;
    k = k * dv * (cs ? 1 : 2);
    repeat (3) @(posedge clk iff pst);
    pq.push_back(k[10:0]);
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(32'h6b62));
    repeat (20) @(posedge clk);
    rstn <= 1;
    r(BLP_ADDR_CLK_SEL, 8'h01);
    r(BLP_ADDR_DIVIDER, BLP_DIV_RESET);
    r(BLP_ADDR_CTRL, 8'h00);
    r(8'h07, 8'h00);
    d = $urandom_range(0, 200);
    for (i = 0; i < 8; i++) go(8'h03 | (i[0] << 2), i >> 1, 1, 0, 0, 0, 1);
    go(8'h03, 1, 1, 8'hd0, 0, 0, 1);
    go(8'h07, 2, 1, 0, 8'h1f, 0, 1);
    d = 8'hf0;
    go(8'h03, 3, 1, 0, 8'h1f, 0, 1);
    go(8'h03, 0, 1, 0, 0, 1, 1);
    go(8'h07, 1, 1, 0, 0, 1, 1);
    go(8'h03, 1, 3, 0, 0, 0, 0);
    go(8'h00, 1, 1, 0, 0, 0, 1);
    go(8'h04, 1, 1, 0, 0, 0, 1);
    w(BLP_ADDR_CTRL, 8'h1b);
    repeat (2) @(posedge clk);
    chk({10'h000, oe}, 11'h000);
    chk({10'h000, bst}, 11'h001);
    tally_and_finish;
  end
endmodule
